// ==== include/fsp_pkg.sv ====
// Shared constants for the flash self-programming sequencer.
// Assumes a 200 MHz core clock; all times are converted to cycles here.
package fsp_pkg;
    // Core clock period in picoseconds
    localparam int unsigned CLK_PERIOD_PS = 5000;
    // Programming time window in microseconds
    localparam int unsigned PROG_MIN_US = 3700;
    localparam int unsigned PROG_MAX_US = 4500;
    // Programming time in whole cycles; cycles per microsecond first keeps the product in range
    localparam int unsigned CYC_PER_US = 1000000 / CLK_PERIOD_PS;
    localparam int unsigned PROG_MIN_CYC = PROG_MIN_US * CYC_PER_US;
    localparam int unsigned PROG_MAX_CYC = PROG_MAX_US * CYC_PER_US;
    // Arming windows in cycles
    localparam logic [2:0] LOAD_WIN = 3'h3;
    localparam logic [2:0] STORE_WIN = 3'h4;
    // Control field positions
    localparam int unsigned CB_ENABLE = 0;
    localparam int unsigned CB_ERASE = 1;
    localparam int unsigned CB_WRITE = 2;
    localparam int unsigned CB_LOCKSEL = 3;
    localparam int unsigned CB_REEN = 4;
    // Pointer values for fuse and lock reads
    localparam logic [15:0] PTR_FUSE_LO = 16'h0000;
    localparam logic [15:0] PTR_LOCK = 16'h0001;
    localparam logic [15:0] PTR_FUSE_HI = 16'h0003;
    // Address map
    localparam int unsigned PC_W = 12;
    localparam int unsigned WORD_W = 5;
    localparam int unsigned PAGE_W = 7;
    localparam logic [11:0] STALL_START = 12'hc00;
    localparam logic [11:0] BOOT_128 = 12'hf80;
    localparam logic [11:0] BOOT_256 = 12'hf00;
    localparam logic [11:0] BOOT_512 = 12'he00;
    localparam logic [11:0] BOOT_1024 = 12'hc00;
    // Reset values
    localparam logic [5:0] LOCK_RESET = 6'h3f;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    // Operation kinds
    typedef enum logic [1:0] {FSP_OP_ERASE, FSP_OP_WRITE, FSP_OP_LOCK} fsp_op_e;
endpackage

// ==== core/fsp_timer.sv ====
// Programming duration timer.
// Assumes start is a one-cycle pulse; the count runs on the core clock.
`timescale 1ns/100ps
module fsp_timer #(
    parameter int unsigned CYCLES = fsp_pkg::PROG_MIN_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic start,
    output logic      done
);
    typedef struct packed {
        logic [23:0] cnt;   // Remaining cycles
        logic        run;   // Timing in progress
        logic        done;  // Completion pulse
    } fsp_tmr_s;

    fsp_tmr_s st_r;
    fsp_tmr_s st_nxt;

    // Count down from the load value to one, then pulse done
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (start) begin
            st_nxt.run = 1'b1;
            st_nxt.cnt = 24'(CYCLES);
        end else if (st_r.run) begin
            if (st_r.cnt <= 24'h000001) begin
                st_nxt.run = 1'b0;
                st_nxt.done = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt - 24'h000001;
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign done = st_r.done;
endmodule

// ==== core/fsp_seq.sv ====
// Flash self-programming sequencer: control bits, fuse and lock readback,
// page buffer loading and erase/write timing with section stall.
// Assumes the CPU presents one-cycle strobes for control writes, store and load.
//
// Overview of operation
// - Pointer 0x0001 load within three returns lock
// - Lock select and enable self-clear on completion/timeout
// - Both bits clear: load reads flash normally
// - Lock byte: boot locks 5..2, memory locks 1..0
// - Pointer 0x0000 load returns fuse low byte
// - Pointer 0x0003 load returns fuse high byte
// - Programmed bits read zero, unprogrammed read one
// - Write in progress completes despite reset
// - Erase, write, lock set last 3.7 to 4.5ms
// - Boot size pair selects boot section start
// - Low 96 pages concurrent, top 32 stall
// - Twelve bit counter, 32 word pages
// - Page select from pointer bits 12..6
// - Word select from pointer bits 5..1
// - Pointer 15..13 ignored, bit 0 byte select
// - Busy flag set on begin, cleared reenable/load
// - Erase/write request with enable arms store
// - Enable alone: store fills buffer word
// - Stall-section programming halts the CPU
`timescale 1ns/100ps
module fsp_seq #(
    parameter int unsigned PROG_CYCLES = fsp_pkg::PROG_MIN_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Control register write
    input  wire logic        ctrl_wr,
    input  wire logic [4:0]  ctrl_wdata,
    // CPU instructions and pointer
    input  wire logic        store_req,
    input  wire logic        load_req,
    input  wire logic [15:0] zptr,
    input  wire logic [15:0] store_data,
    // Flash array read data for ordinary loads
    input  wire logic [15:0] flash_rdata,
    // Nonvolatile configuration
    input  wire logic [7:0]  fuse_low_byte,
    input  wire logic [7:0]  fuse_high_byte,
    input  wire logic [5:0]  lock_init,
    input  wire logic        boot_size_hi,
    input  wire logic        boot_size_lo,
    // Fetch side
    input  wire logic [11:0] fetch_addr,
    // Status and results
    output logic [7:0]       self_prog_ctrl_status,
    output logic [7:0]       load_data,
    output logic             load_valid,
    output logic             cpu_halt,
    output logic             fetch_busy,
    output logic [11:0]      boot_start,
    // Flash array commands
    output logic             buf_wr,
    output logic [4:0]       buf_word,
    output logic [15:0]      buf_data,
    output logic             buf_clear,
    output logic             page_erase_go,
    output logic             page_write_go,
    output logic [6:0]       prog_page
);
    typedef enum logic [1:0] {FSP_IDLE, FSP_BUSY} fsp_state_e;

    typedef struct packed {
        fsp_state_e  state;                 // Programming state
        logic        self_prog_enable;      // Enable bit
        logic        page_erase_req;        // Erase request
        logic        page_write_req;        // Write request
        logic        lock_read_select;      // Lock select / set
        logic        section_reenable;      // Reenable request
        logic        section_busy_flag;     // Concurrent section busy
        logic [2:0]  win;                   // Arming window counter
        logic [5:0]  lock_bits;             // Stored lock bits
        logic        lock_loaded;           // Lock bits captured from strap
        logic        halt;                  // CPU halt
        logic [7:0]  ldata;                 // Load result
        logic        lvalid;                // Load result valid
        logic        bwr;                   // Buffer write strobe
        logic [4:0]  bword;                 // Buffer word
        logic [15:0] bdata;                 // Buffer data
        logic        bclr;                  // Buffer clear
        logic        ergo;                  // Erase strobe
        logic        wrgo;                  // Write strobe
        logic [6:0]  page;                  // Latched page
        logic        lockop;                // Lock write in progress
        logic [5:0]  lock_pend;             // Pending lock value
        logic [11:0] bstart;                // Boot section start
        logic        fbusy;                 // Fetch blocked
    } fsp_seq_s;

    fsp_seq_s st_r;
    fsp_seq_s st_nxt;
    logic     tmr_start;
    logic     tmr_done;
    logic     tmr_rst;                      // Timer reset, withheld while an operation runs
    logic     armed;
    logic     lock_read;
    logic     in_stall;
    logic [7:0] fuse_sel;

    // Programming timer
    fsp_timer #(
        .CYCLES (PROG_CYCLES)
    ) u_timer (
        .clk   (clk),
        .rst   (tmr_rst),
        .start (tmr_start),
        .done  (tmr_done)
    );

    // A reset in mid-operation must not lose the running count
    assign tmr_rst = rst && (st_r.state != FSP_BUSY);

    // Decode helpers
    always_comb begin
        armed = st_r.self_prog_enable && (st_r.win != 3'h0);
        lock_read = armed && st_r.lock_read_select
                    && (st_r.win > (fsp_pkg::STORE_WIN - fsp_pkg::LOAD_WIN));
        in_stall = (zptr[12:1] >= fsp_pkg::STALL_START);
        // Fuse/lock byte selection by low pointer bits only
        case (zptr[12:0])
            13'(fsp_pkg::PTR_LOCK):    fuse_sel = {2'h3, st_r.lock_bits};
            13'(fsp_pkg::PTR_FUSE_LO): fuse_sel = fuse_low_byte;
            13'(fsp_pkg::PTR_FUSE_HI): fuse_sel = fuse_high_byte;
            default:                   fuse_sel = 8'hff;
        endcase
    end

    // Next-state logic
    always_comb begin
        st_nxt = st_r;
        tmr_start = 1'b0;
        st_nxt.lvalid = 1'b0;
        st_nxt.bwr = 1'b0;
        st_nxt.bclr = 1'b0;
        st_nxt.ergo = 1'b0;
        st_nxt.wrgo = 1'b0;
        // Lock bits captured once after reset release
        if (!st_r.lock_loaded) begin
            st_nxt.lock_bits = lock_init;
            st_nxt.lock_loaded = 1'b1;
        end
        // Boot section start from size pair
        case ({boot_size_hi, boot_size_lo})
            2'h3:    st_nxt.bstart = fsp_pkg::BOOT_128;
            2'h2:    st_nxt.bstart = fsp_pkg::BOOT_256;
            2'h1:    st_nxt.bstart = fsp_pkg::BOOT_512;
            default: st_nxt.bstart = fsp_pkg::BOOT_1024;
        endcase
        case (st_r.state)
            FSP_IDLE: begin
                // Window counts down; expiry clears all request bits
                if (st_r.win != 3'h0) begin
                    st_nxt.win = st_r.win - 3'h1;
                    if (st_r.win == 3'h1) begin
                        st_nxt.self_prog_enable = 1'b0;
                        st_nxt.page_erase_req = 1'b0;
                        st_nxt.page_write_req = 1'b0;
                        st_nxt.lock_read_select = 1'b0;
                        st_nxt.section_reenable = 1'b0;
                    end
                end
                // Lock select window for loads is shorter than for stores
                if (st_r.lock_read_select && st_r.win == fsp_pkg::STORE_WIN - fsp_pkg::LOAD_WIN
                    && !store_req && !load_req) begin
                    st_nxt.lock_read_select = 1'b0;
                    st_nxt.self_prog_enable = 1'b0;
                    st_nxt.win = 3'h0;
                end
                if (ctrl_wr) begin
                    st_nxt.self_prog_enable = ctrl_wdata[fsp_pkg::CB_ENABLE];
                    st_nxt.page_erase_req = ctrl_wdata[fsp_pkg::CB_ERASE];
                    st_nxt.page_write_req = ctrl_wdata[fsp_pkg::CB_WRITE];
                    st_nxt.lock_read_select = ctrl_wdata[fsp_pkg::CB_LOCKSEL];
                    st_nxt.section_reenable = ctrl_wdata[fsp_pkg::CB_REEN];
                    st_nxt.win = ctrl_wdata[fsp_pkg::CB_ENABLE] ? fsp_pkg::STORE_WIN : 3'h0;
                end else if (load_req) begin
                    if (lock_read) begin
                        st_nxt.ldata = fuse_sel;
                        st_nxt.lock_read_select = 1'b0;
                        st_nxt.self_prog_enable = 1'b0;
                        st_nxt.win = 3'h0;
                    end else begin
                        // Ordinary flash byte, pointer bit 0 picks the byte
                        st_nxt.ldata = zptr[0] ? flash_rdata[15:8] : flash_rdata[7:0];
                    end
                    st_nxt.lvalid = 1'b1;
                end else if (store_req && armed) begin
                    st_nxt.win = 3'h0;
                    st_nxt.self_prog_enable = 1'b0;
                    if (st_r.page_erase_req || st_r.page_write_req) begin
                        st_nxt.page = zptr[12:6];
                        st_nxt.ergo = st_r.page_erase_req;
                        st_nxt.wrgo = st_r.page_write_req;
                        st_nxt.self_prog_enable = 1'b1;
                        st_nxt.state = FSP_BUSY;
                        tmr_start = 1'b1;
                        if (in_stall) begin
                            st_nxt.halt = 1'b1;
                        end else begin
                            st_nxt.section_busy_flag = 1'b1;
                        end
                    end else if (st_r.lock_read_select) begin
                        st_nxt.lockop = 1'b1;
                        st_nxt.lock_pend = store_data[5:0];
                        st_nxt.self_prog_enable = 1'b1;
                        st_nxt.state = FSP_BUSY;
                        tmr_start = 1'b1;
                    end else if (st_r.section_reenable) begin
                        st_nxt.section_reenable = 1'b0;
                        st_nxt.section_busy_flag = 1'b0;
                        st_nxt.bclr = 1'b1;
                    end else begin
                        st_nxt.bwr = 1'b1;
                        st_nxt.bword = zptr[5:1];
                        st_nxt.bdata = store_data;
                        st_nxt.section_busy_flag = 1'b0;
                    end
                end
            end
            FSP_BUSY: begin
                // Control writes are ignored until the operation ends
                if (tmr_done) begin
                    st_nxt.state = FSP_IDLE;
                    st_nxt.self_prog_enable = 1'b0;
                    st_nxt.page_erase_req = 1'b0;
                    st_nxt.page_write_req = 1'b0;
                    st_nxt.lock_read_select = 1'b0;
                    st_nxt.halt = 1'b0;
                    if (st_r.page_write_req) begin
                        st_nxt.bclr = 1'b1;
                    end
                    if (st_r.lockop) begin
                        // Only programming (to zero) is possible
                        st_nxt.lock_bits = st_r.lock_bits & st_r.lock_pend;
                        st_nxt.lockop = 1'b0;
                    end
                end
            end
            default: st_nxt.state = FSP_IDLE;
        endcase
        st_nxt.fbusy = st_nxt.section_busy_flag
                       && (fetch_addr < fsp_pkg::STALL_START);
    end

    // State register; a running operation survives reset
    always_ff @(posedge clk) begin
        if (rst && st_r.state != FSP_BUSY) begin
            st_r <= '0;
            st_r.bclr <= 1'b1;
            st_r.bstart <= fsp_pkg::BOOT_1024;
        end else if (rst) begin
            st_r <= st_nxt;
            st_r.win <= 3'h0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from state flops
    assign self_prog_ctrl_status = {1'b0, st_r.section_busy_flag, 1'b0, st_r.section_reenable,
                                    st_r.lock_read_select, st_r.page_write_req,
                                    st_r.page_erase_req, st_r.self_prog_enable};
    assign load_data = st_r.ldata;
    assign load_valid = st_r.lvalid;
    assign cpu_halt = st_r.halt;
    assign fetch_busy = st_r.fbusy;
    assign boot_start = st_r.bstart;
    assign buf_wr = st_r.bwr;
    assign buf_word = st_r.bword;
    assign buf_data = st_r.bdata;
    assign buf_clear = st_r.bclr;
    assign page_erase_go = st_r.ergo;
    assign page_write_go = st_r.wrgo;
    assign prog_page = st_r.page;

    // Assertions
    a_halt_stall: assert property (@(posedge clk) disable iff (rst)
        (st_r.state == FSP_IDLE && store_req && armed && !ctrl_wr && !load_req
         && (st_r.page_erase_req || st_r.page_write_req) && in_stall)
        |=> cpu_halt) else $error("No halt for stall section");
    a_busy_set: assert property (@(posedge clk) disable iff (rst)
        (st_r.state == FSP_IDLE && store_req && armed && !ctrl_wr && !load_req
         && st_r.page_write_req && !in_stall)
        |=> self_prog_ctrl_status[6]) else $error("Busy flag not set");
    a_win_expire: assert property (@(posedge clk) disable iff (rst)
        (st_r.state == FSP_IDLE && ctrl_wr && ctrl_wdata == 5'h01) ##1
        (!store_req && !load_req && !ctrl_wr)[*4] |=> !self_prog_ctrl_status[0])
        else $error("Enable did not time out");
    a_load_lock: assert property (@(posedge clk) disable iff (rst)
        (st_r.state == FSP_IDLE && load_req && !ctrl_wr && lock_read && zptr[12:0] == 13'h0001)
        |=> load_data == {2'h3, $past(st_r.lock_bits)}) else $error("Lock byte wrong");
    a_load_plain: assert property (@(posedge clk) disable iff (rst)
        (st_r.state == FSP_IDLE && load_req && !ctrl_wr && !armed && !zptr[0])
        |=> load_data == $past(flash_rdata[7:0])) else $error("Plain load wrong");
    a_fill_word: assert property (@(posedge clk) disable iff (rst)
        (st_r.state == FSP_IDLE && store_req && !ctrl_wr && !load_req && armed
         && !st_r.page_erase_req && !st_r.page_write_req && !st_r.lock_read_select
         && !st_r.section_reenable)
        |=> buf_wr && buf_word == $past(zptr[5:1])) else $error("Buffer word wrong");
    a_page_sel: assert property (@(posedge clk) disable iff (rst)
        $rose(page_erase_go) |-> prog_page == $past(zptr[12:6])) else $error("Page wrong");
    a_prog_end: assert property (@(posedge clk) disable iff (rst)
        tmr_done && st_r.state == FSP_BUSY |=> !self_prog_ctrl_status[0] && !cpu_halt)
        else $error("Operation did not end");
endmodule

// ==== tb/fsp_cpu_model.sv ====
// CPU core model: control writes, store and load instructions.
// Assumes callers enter each task just after a rising clock edge.
`timescale 1ns/100ps
module fsp_cpu_model (
    // Clock
    input  wire logic        clk,
    // Load result
    input  wire logic [7:0]  load_data,
    input  wire logic        load_valid,
    // Instruction strobes and operands
    output logic             ctrl_wr,
    output logic [4:0]       ctrl_wdata,
    output logic             store_req,
    output logic             load_req,
    output logic [15:0]      zptr,
    output logic [15:0]      store_data,
    // Flash array word seen by ordinary loads
    output logic [15:0]      flash_rdata
);
    // Array content is a fixed pattern of the word address
    assign flash_rdata = {4'h9, zptr[12:1]} ^ 16'h3c3c;
    // Idle levels at time zero
    initial begin
        ctrl_wr    = 1'b0;
        ctrl_wdata = 5'h00;
        store_req  = 1'b0;
        load_req   = 1'b0;
        zptr       = 16'h0000;
        store_data = 16'hffff;
    end
    // Control write, one cycle strobe
    task automatic ctrl(input logic [4:0] w);
        ctrl_wr    = 1'b1;
        ctrl_wdata = w;
        @(posedge clk);
        #1;
        ctrl_wr    = 1'b0;
        ctrl_wdata = ~w;  // Released operand does not keep its value
    endtask
    // Store issued in the four-cycle window; Z5:Z1 and Z0 as caller gives
    task automatic store(input logic [15:0] z, input logic [15:0] d);
        zptr       = z;
        store_data = d;
        store_req  = 1'b1;
        @(posedge clk);
        #1;
        store_req  = 1'b0;
        store_data = ~d;  // Released operand does not keep its value
    endtask
    // Load issued in the three-cycle window; result taken one edge later
    task automatic load(input logic [15:0] z, output logic [7:0] d, output logic v);
        zptr     = z;
        load_req = 1'b1;
        @(posedge clk);
        #1;
        load_req = 1'b0;
        v        = load_valid;
        d        = load_data;
    endtask
endmodule

// ==== tb/tb_fsp_seq.sv ====
// Self-checking bench for the self-programming sequencer.
// Assumes the CPU model beside it and a shortened programming time.
`timescale 1ns/100ps
module tb_fsp_seq;
    localparam int unsigned PROG = 20;  // Shortened programming time
    // Clock, reset and configuration
    logic        clk, rst, bsz_hi, bsz_lo;
    logic [7:0]  fuse_lo, fuse_hi, status, load_data;
    logic [5:0]  lock_in;
    logic [11:0] fetch_addr, boot_start;
    // CPU side
    logic        ctrl_wr, store_req, load_req, load_valid;
    logic [4:0]  ctrl_wdata, buf_word;
    logic [15:0] zptr, store_data, flash_rdata, buf_data;
    // Flash and fetch side
    logic        cpu_halt, fetch_busy, buf_wr, buf_clear, erase_go, write_go;
    logic [6:0]  prog_page;
    int          num_errors = 0;
    int          num_checks = 0;
    // Core clock, 5 ns period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    fsp_seq #(.PROG_CYCLES(PROG)) i_dut (.clk(clk), .rst(rst), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .store_req(store_req), .load_req(load_req), .zptr(zptr),
        .store_data(store_data), .flash_rdata(flash_rdata), .fuse_low_byte(fuse_lo),
        .fuse_high_byte(fuse_hi), .lock_init(lock_in), .boot_size_hi(bsz_hi),
        .boot_size_lo(bsz_lo), .fetch_addr(fetch_addr), .self_prog_ctrl_status(status),
        .load_data(load_data), .load_valid(load_valid), .cpu_halt(cpu_halt),
        .fetch_busy(fetch_busy), .boot_start(boot_start), .buf_wr(buf_wr),
        .buf_word(buf_word), .buf_data(buf_data), .buf_clear(buf_clear),
        .page_erase_go(erase_go), .page_write_go(write_go), .prog_page(prog_page));
    fsp_cpu_model i_cpu (.clk(clk), .load_data(load_data), .load_valid(load_valid),
        .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .store_req(store_req),
        .load_req(load_req), .zptr(zptr), .store_data(store_data), .flash_rdata(flash_rdata));
    // Compare a value
    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Compare a flag
    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_val(what, {15'h0000, exp}, {15'h0000, got});
    endtask
    // Counts and verdict
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Let whole cycles pass, ending just after an edge
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask
    // Bounded wait for the running operation to finish
    task automatic wait_done(output int n);
        n = 0;
        while ((status[0] === 1'b1 || cpu_halt === 1'b1) && n < 200) begin
            idle(1);
            n++;
        end
        if (n >= 200) begin
            num_errors++;
            $display("[FAIL] op done expected 1 seen 0");
            stop_test();
        end
    endtask
    // Boot start for every boot-size code
    task automatic t_boot();
        logic [11:0] exp [4] = '{fsp_pkg::BOOT_1024, fsp_pkg::BOOT_512,
                                 fsp_pkg::BOOT_256, fsp_pkg::BOOT_128};
        for (int i = 0; i < 4; i++) begin
            {bsz_hi, bsz_lo} = 2'(i);
            idle(2);
            chk_val("boot_start", 16'(exp[i]), 16'(boot_start));
        end
        $display("boot size test done");
    endtask
    // Fuse and lock reads at window edges, high pointer bits set once
    task automatic t_cfg_read();
        logic [15:0] ptr [3] = '{16'h0000, 16'he001, 16'h0003};
        logic [7:0]  exp [3];
        logic [7:0]  got;
        logic        v;
        for (int i = 0; i < 3; i++) begin
            for (int d = 1; d <= 3; d += 2) begin
                fuse_lo = fuse_lo ^ 8'hff;  // Fresh fuse levels on every pass
                fuse_hi = {fuse_hi[6:0], fuse_hi[7]};
                exp = '{fuse_lo, {2'b11, lock_in}, fuse_hi};
                i_cpu.ctrl(5'h09);
                idle(d - 1);
                i_cpu.load(ptr[i], got, v);
                chk_bit("cfg valid", 1'b1, v);
                chk_val("cfg byte", 16'(exp[i]), 16'(got));
                chk_val("status", 16'h0000, 16'(status));
            end
        end
        $display("config read test done");
    endtask
    // Late load and plain load read the array
    task automatic t_late_read();
        logic [7:0] got;
        logic       v;
        i_cpu.ctrl(5'h09);
        idle(3);
        i_cpu.load(16'h0001, got, v);
        chk_val("late load", 16'(flash_rdata[15:8]), 16'(got));
        chk_val("status", 16'h0000, 16'(status));
        i_cpu.load(16'h0000, got, v);
        chk_val("plain load", 16'(flash_rdata[7:0]), 16'(got));
        $display("late read test done");
    endtask
    // Buffer fill at the last window cycle, then one cycle too late
    task automatic t_fill();
        i_cpu.ctrl(5'h01);
        idle(3);
        i_cpu.store(16'h003f, 16'hbeef);  // Z0 set on purpose, must be ignored
        chk_bit("buf_wr", 1'b1, buf_wr);
        chk_val("buf_word", 16'h001f, 16'(buf_word));
        chk_val("buf_data", 16'hbeef, buf_data);
        chk_val("status", 16'h0000, 16'(status));
        i_cpu.ctrl(5'h01);
        idle(4);
        i_cpu.store(16'h0002, 16'h1234);
        chk_bit("late buf_wr", 1'b0, buf_wr);
        $display("fill test done");
    endtask
    // One erase or write, judged at launch and at completion
    task automatic t_prog(input logic [4:0] cmd, input logic [15:0] z, input logic stall);
        int n;
        i_cpu.ctrl(cmd);
        i_cpu.store(z, 16'hffff);
        chk_bit("erase_go", cmd == 5'h03, erase_go);
        chk_bit("write_go", cmd == 5'h05, write_go);
        chk_val("prog_page", 16'(z[12:6]), 16'(prog_page));
        chk_bit("cpu_halt", stall, cpu_halt);
        chk_bit("busy flag", !stall, status[6]);
        wait_done(n);
        chk_bit("op time", n >= PROG && n <= PROG + 4, 1'b1);
    endtask
    // Section boundary, busy flag and its two ways of clearing
    task automatic t_sections();
        fetch_addr = 12'hbff;
        t_prog(5'h03, 16'h17c0, 1'b0);  // Last page of the concurrent section
        chk_bit("busy held", 1'b1, status[6]);
        chk_bit("fetch blocked", 1'b1, fetch_busy);
        fetch_addr = 12'hc00;
        idle(2);
        chk_bit("stall fetch", 1'b0, fetch_busy);
        i_cpu.ctrl(5'h11);
        i_cpu.store(16'h0000, 16'hffff);
        chk_bit("buf_clear", 1'b1, buf_clear);
        chk_bit("busy cleared", 1'b0, status[6]);
        t_prog(5'h05, 16'h0140, 1'b0);
        i_cpu.ctrl(5'h01);
        i_cpu.store(16'h0140, 16'h1234);
        chk_bit("load clears busy", 1'b0, status[6]);
        t_prog(5'h05, 16'h1800, 1'b1);  // First page of the stall section
        $display("section test done");
    endtask
    // Lock write then read back
    task automatic t_lock_set();
        int         n;
        logic [7:0] got;
        logic       v;
        i_cpu.ctrl(5'h09);
        i_cpu.store(16'h0001, 16'h00f3);
        wait_done(n);
        chk_bit("lock time", n >= PROG && n <= PROG + 4, 1'b1);
        i_cpu.ctrl(5'h09);
        i_cpu.load(16'h0001, got, v);
        chk_val("lock byte", 16'h00e1, 16'(got));
        $display("lock set test done");
    endtask
    // Reset in mid-write does not stop the write
    task automatic t_reset_mid();
        int         n;
        logic [7:0] got;
        logic       v;
        i_cpu.ctrl(5'h05);
        i_cpu.store(16'h1800, 16'hffff);
        idle(5);
        rst = 1'b1;
        idle(1);
        rst = 1'b0;
        chk_bit("halt across reset", 1'b1, cpu_halt);
        wait_done(n);
        chk_bit("write finished", n <= PROG, 1'b1);
        lock_in = 6'h1e;  // New lock strap, taken only by an idle reset
        rst = 1'b1;
        idle(2);
        rst = 1'b0;
        chk_bit("buf_clear on reset", 1'b1, buf_clear);
        idle(1);
        i_cpu.ctrl(5'h09);
        i_cpu.load(16'h0001, got, v);
        chk_val("lock after reset", 16'h00de, 16'(got));
        $display("reset test done");
    endtask
    // Main sequence
    initial begin
        rst        = 1'b1;
        {bsz_hi, bsz_lo} = 2'b00;
        fuse_lo    = 8'h96;
        fuse_hi    = 8'h5a;
        lock_in    = 6'h2d;
        fetch_addr = 12'h000;
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        idle(2);
        chk_val("status", 16'h0000, 16'(status));
        t_boot();
        t_cfg_read();
        t_late_read();
        t_fill();
        t_sections();
        t_lock_set();
        t_reset_mid();
        stop_test();
    end
endmodule
